// file: rtl/pwm_mask_regs.sv
// Purpose: slave window mask bank, mirrors, cache line length, window decode
// Assumes: one 200 MHz clock, synchronous reset, plain register port
// Notes:   read data valid in the cycle after the read strobe
//
// How it works
// RULE_01 - a stored cache line length of 10h means a 64-byte line.
// RULE_02 - a stored cache line length of 20h means a 128-byte line, the largest.
// RULE_03 - writing an unsupported cache line length stores zero, disabling the line function.
// RULE_04 - six mask registers, one per slave window, set size and prefetchability.
// RULE_05 - mask bits 31 to 4 gate which mirror bits a host write may change.
// RULE_06 - mask bit 3 is shown as the prefetchable flag of the paired mirror.
// RULE_07 - a window with its decode enable clear ignores accesses, yet its mirror stays writable.
// RULE_08 - mirror bits with mask zero hold their value, so all-ones readback shows the size.
//
// Implementation choices: the strobed register port and the register offsets.
module pwm_mask_regs
	import pwm_pkg::*;
#(
	parameter int NWIN = NUM_WIN
) (
	input  wire logic              SYS_CLK_I,
	input  wire logic              RST_I,
	input  wire logic [7:0]        ADDR_I,
	input  wire logic [31:0]       WDATA_I,
	input  wire logic              WR_I,
	input  wire logic              RD_I,
	output logic      [31:0]       RDATA_O,
	input  wire logic [31:0]       ACC_ADDR_I,
	input  wire logic              ACC_VALID_I,
	output logic                   ACC_HIT_O,
	output logic      [2:0]        ACC_WIN_O,
	output logic                   ACC_BAR_PREFETCHABLE_FLAG_O,
	output logic      [7:0]        LINE_BYTES_O
);
	import pwm_pkg::*;

	// ==========================================
	// elaboration check
	if (NWIN != NUM_WIN) begin : g_bad_nwin
		$error("window count must match the register map");
	end

	logic [31:0] mask_r [NUM_WIN];
	logic [7:0]  cache_len_r;
	logic [5:0]  win_en_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [7:0]  line_bytes_r;
	logic        hit_r;
	logic [2:0]  hit_win_r;
	logic        hit_pref_r;
	logic [31:0] mirror [NUM_WIN];
	pwm_op_e     op;

	pwm_win_if win_if [NUM_WIN] ();

	// ==========================================
	// decode of strobe type
	always_comb begin
		if (WR_I) begin
			op = PWM_WRITE;
		end else if (RD_I) begin
			op = PWM_READ;
		end else begin
			op = PWM_IDLE;
		end
	end

	// ==========================================
	// per-window mask registers and mirrors
	for (genvar n = 0; n < NUM_WIN; n++) begin : g_win
		localparam logic [7:0] MASK_ADR = OFS_MASK0 + 8'(4 * n);
		localparam logic [7:0] MIR_ADR  = OFS_MIRROR0 + 8'(4 * n);

		// mask write, reserved bits stay zero
		always_ff @(posedge SYS_CLK_I) begin
			if (RST_I) begin
				mask_r[n] <= MASK_RESET;
			end else if (op == PWM_WRITE && ADDR_I == MASK_ADR) begin
				mask_r[n] <= WDATA_I & (MASK_FIELD | (32'h1 << PREF_BIT)); // RULE_04
			end
		end

		// mirror writes regardless of decode enable
		always_comb begin
			win_if[n].mask  = mask_r[n];
			win_if[n].wr    = (op == PWM_WRITE) && (ADDR_I == MIR_ADR); // RULE_07
			win_if[n].wdata = WDATA_I;
			mirror[n]       = win_if[n].mirror;
		end

		pwm_win_mirror u_mirror (
			.clk_i (SYS_CLK_I),
			.rst_i (RST_I),
			.win   (win_if[n])
		);
	end

	// ==========================================
	// cache line length, unsupported codes become zero
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			cache_len_r <= CL_OFF;
		end else if (op == PWM_WRITE && ADDR_I == OFS_CACHE_LINE) begin
			cache_len_r <= pwm_cl_filter(WDATA_I[7:0]); // RULE_03
		end
	end

	// line length in bytes
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			line_bytes_r <= 8'h00;
		end else begin
			line_bytes_r <= pwm_cl_bytes(cache_len_r); // RULE_01 RULE_02
		end
	end

	// ==========================================
	// window decode enables
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			win_en_r <= WIN_EN_RESET;
		end else if (op == PWM_WRITE && ADDR_I == OFS_WIN_ENABLE) begin
			win_en_r <= WDATA_I[5:0];
		end
	end

	// ==========================================
	// access decode, lowest enabled matching window wins
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			hit_r      <= 1'b0;
			hit_win_r  <= 3'h0;
			hit_pref_r <= 1'b0;
		end else begin
			hit_r      <= 1'b0;
			hit_win_r  <= 3'h0;
			hit_pref_r <= 1'b0;
			for (int k = NUM_WIN - 1; k >= 0; k--) begin
				if (ACC_VALID_I && win_en_r[k] &&
					((ACC_ADDR_I & mask_r[k] & MASK_FIELD) ==
					 (mirror[k] & mask_r[k] & MASK_FIELD))) begin // RULE_07
					hit_r      <= 1'b1;
					hit_win_r  <= 3'(k);
					hit_pref_r <= mask_r[k][PREF_BIT]; // RULE_06
				end
			end
		end
	end

	// ==========================================
	// read mux
	always_comb begin
		rdata_nxt = 32'h0;
		for (int k = 0; k < NUM_WIN; k++) begin
			if (ADDR_I == OFS_MASK0 + 8'(4 * k)) begin
				rdata_nxt = mask_r[k];
			end
			if (ADDR_I == OFS_MIRROR0 + 8'(4 * k)) begin
				rdata_nxt = mirror[k]; // RULE_08
			end
		end
		if (ADDR_I == OFS_CACHE_LINE) begin
			rdata_nxt = {24'h0, cache_len_r};
		end
		if (ADDR_I == OFS_WIN_ENABLE) begin
			rdata_nxt = {26'h0, win_en_r};
		end
		if (ADDR_I == OFS_LINE_BYTES) begin
			rdata_nxt = {24'h0, line_bytes_r};
		end
	end

	// read data held one cycle only
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rdata_r <= 32'h0;
		end else if (op == PWM_READ) begin
			rdata_r <= rdata_nxt;
		end else begin
			rdata_r <= 32'h0;
		end
	end

	assign RDATA_O        = rdata_r;
	assign ACC_HIT_O      = hit_r;
	assign ACC_WIN_O      = hit_win_r;
	assign ACC_BAR_PREFETCHABLE_FLAG_O = hit_pref_r;
	assign LINE_BYTES_O   = line_bytes_r;

	// ==========================================
	// checks
	cl_sixty_four_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(cache_len_r == CL_64B) |=> (LINE_BYTES_O == BYTES_64))
		else $error("10h not decoded as 64 bytes"); // RULE_01
	cl_max_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(cache_len_r == CL_128B) |=> (LINE_BYTES_O == BYTES_128))
		else $error("20h not decoded as 128 bytes"); // RULE_02
	cl_filter_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(WR_I && ADDR_I == OFS_CACHE_LINE && WDATA_I[7:0] == 8'h11) |=> (cache_len_r == CL_OFF))
		else $error("unsupported line length kept"); // RULE_03
	cl_legal_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(pwm_cl_filter(cache_len_r) == cache_len_r))
		else $error("illegal line length stored"); // RULE_03
	mask_rsvd_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(mask_r[0][2:0] == 3'h0) && (mask_r[NUM_WIN-1][2:0] == 3'h0))
		else $error("mask reserved bits set"); // RULE_04
	mask_write_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(WR_I && ADDR_I == OFS_MASK0) |=> (mask_r[0][31:4] == $past(WDATA_I[31:4])))
		else $error("mask write lost"); // RULE_04
	off_win_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(win_en_r == 6'h00) |=> !ACC_HIT_O)
		else $error("disabled window hit"); // RULE_07
	read_slot_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
		(RD_I && ADDR_I == OFS_WIN_ENABLE) |=> (RDATA_O == {26'h0, $past(win_en_r)}))
		else $error("read data wrong"); // RULE_08
endmodule : pwm_mask_regs

// file: rtl/pwm_pkg.sv
// Purpose: shared constants for the slave window mask register bank
// Assumes: 32-bit register port, six slave windows
// Notes:   offsets are byte addresses on the plain register port
package pwm_pkg;

	// ==========================================
	// register map
	localparam int          NUM_WIN          = 6;
	localparam logic [7:0]  OFS_MASK0        = 8'h00;  // mask n at OFS_MASK0 + 4*n
	localparam logic [7:0]  OFS_MIRROR0      = 8'h20;  // mirror n at OFS_MIRROR0 + 4*n
	localparam logic [7:0]  OFS_CACHE_LINE   = 8'h40;
	localparam logic [7:0]  OFS_WIN_ENABLE   = 8'h44;
	localparam logic [7:0]  OFS_LINE_BYTES   = 8'h48;

	// ==========================================
	// field layout
	localparam int          MASK_LSB         = 4;
	localparam int          PREF_BIT         = 3;
	localparam logic [31:0] MASK_FIELD       = 32'hFFFF_FFF0;
	localparam logic [31:0] MASK_RESET       = 32'hFF80_0008;  // size field, bar_prefetchable_flag set
	localparam logic [31:0] MIRROR_RESET     = 32'h0000_0000;
	localparam logic [5:0]  WIN_EN_RESET     = 6'h00;

	// ==========================================
	// cache line length encodings (32-bit words)
	localparam logic [7:0]  CL_OFF           = 8'h00;
	localparam logic [7:0]  CL_16B           = 8'h04;
	localparam logic [7:0]  CL_32B           = 8'h08;
	localparam logic [7:0]  CL_64B           = 8'h10;
	localparam logic [7:0]  CL_128B          = 8'h20;
	localparam logic [7:0]  BYTES_16         = 8'h10;
	localparam logic [7:0]  BYTES_32         = 8'h20;
	localparam logic [7:0]  BYTES_64         = 8'h40;
	localparam logic [7:0]  BYTES_128        = 8'h80;

	typedef enum logic [1:0] {PWM_IDLE, PWM_WRITE, PWM_READ} pwm_op_e;

	// legal encoding or zero
	function automatic logic [7:0] pwm_cl_filter(input logic [7:0] v);
		case (v)
			CL_16B, CL_32B, CL_64B, CL_128B: pwm_cl_filter = v;
			default: pwm_cl_filter = CL_OFF;
		endcase
	endfunction : pwm_cl_filter

	// line length in bytes for a stored encoding
	function automatic logic [7:0] pwm_cl_bytes(input logic [7:0] v);
		case (v)
			CL_16B:  pwm_cl_bytes = BYTES_16;
			CL_32B:  pwm_cl_bytes = BYTES_32;
			CL_64B:  pwm_cl_bytes = BYTES_64;
			CL_128B: pwm_cl_bytes = BYTES_128;
			default: pwm_cl_bytes = 8'h00;
		endcase
	endfunction : pwm_cl_bytes

endpackage : pwm_pkg

// file: rtl/pwm_win_if.sv
// Purpose: carries one window's mask and mirror state between modules
// Assumes: pwm_pkg compiled first
// Notes:   one instance per window
interface pwm_win_if;
	logic [31:0] mask;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] mirror;

	modport bank   (output mask, output wr, output wdata, input mirror);
	modport window (input mask, input wr, input wdata, output mirror);
endinterface : pwm_win_if

// file: rtl/pwm_win_mirror.sv
// Purpose: one base address mirror with mask-gated writes
// Assumes: synchronous active-high reset
// Notes:   read data registered in the parent
module pwm_win_mirror
	import pwm_pkg::*;
(
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	pwm_win_if.window  win
);
	logic [31:0] base_r;

	// ==========================================
	// masked base update
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			base_r <= MIRROR_RESET;
		end else if (win.wr) begin
			base_r <= (win.wdata & win.mask & MASK_FIELD) | (base_r & ~(win.mask & MASK_FIELD)); // RULE_05 RULE_08
		end
	end

	// bar_prefetchable_flag flag comes from the mask register
	always_comb begin
		win.mirror = {base_r[31:MASK_LSB], win.mask[PREF_BIT], 3'h0}; // RULE_06
	end

	mirror_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		win.wr |=> ((base_r & ~win.mask & MASK_FIELD) == ($past(base_r) & ~win.mask & MASK_FIELD)))
		else $error("unmasked mirror bit changed"); // RULE_08
	mirror_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		win.wr |=> ((base_r & win.mask & MASK_FIELD) == ($past(win.wdata) & win.mask & MASK_FIELD)))
		else $error("masked mirror bit not written"); // RULE_05
	pref_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		win.mirror[PREF_BIT] == win.mask[PREF_BIT])
		else $error("bar_prefetchable_flag flag mismatch"); // RULE_06
endmodule : pwm_win_mirror

// file: sim/pwm_host_model.sv
// Purpose: host side of the mask bank: register port and slave accesses
// Assumes: one clock, answers one cycle after each strobe or access
// Notes:   released lines show the inverse of the last value driven
module pwm_host_model (
	input  wire logic        clk_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic        hit_i,
	input  wire logic [2:0]  win_i,
	input  wire logic        pf_i,
	output logic      [7:0]  addr_o,
	output logic      [31:0] wdata_o,
	output logic             wr_o,
	output logic             rd_o,
	output logic      [31:0] acc_addr_o,
	output logic             acc_valid_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// ==========================================
	// idle levels at time zero
	initial begin
		addr_o      <= 8'h00;
		wdata_o     <= 32'h0000_0000;
		wr_o        <= 1'b0;
		rd_o        <= 1'b0;
		acc_addr_o  <= 32'h0000_0000;
		acc_valid_o <= 1'b0;
	end

	// ==========================================
	// one-cycle write, lines scrambled once released
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o  <= a;
		wdata_o <= d;
		wr_o    <= 1'b1;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		addr_o  <= ~a;
		wdata_o <= ~d;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o   <= 1'b1;
		@(posedge clk_i);
		rd_o   <= 1'b0;
		addr_o <= ~a;
		#1 d = rdata_i;
	endtask : rd

	// one slave access, decode result in the next cycle
	task automatic acc(input logic [31:0] a, output logic h, output logic [2:0] w,
			output logic p);
		@(posedge clk_i);
		acc_addr_o  <= a;
		acc_valid_o <= 1'b1;
		@(posedge clk_i);
		acc_valid_o <= 1'b0;
		acc_addr_o  <= ~a;
		#1;
		h = hit_i;
		w = win_i;
		p = pf_i;
	endtask : acc
endmodule : pwm_host_model

// file: sim/pwm_mask_regs_tb.sv
// Purpose: self-checking bench for the window mask bank
// Assumes: register map and reset values of pwm_pkg
// Notes:   all traffic goes through the host model tasks
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
	$display("mismatch at %0t: got %h exp %h", $time, (got), (exp)); end end
module pwm_mask_regs_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import pwm_pkg::*;

	logic        clk, rst, wr, rd, acc_valid, hit, pf, h_s, p_s;
	logic [7:0]  addr, line_bytes;
	logic [31:0] wdata, rdata, acc_addr, d, m, old, e;
	logic [2:0]  win, w_s;
	int          miscompares, samples_checked;
	logic [7:0]  cl_in [9] = '{8'h00, 8'h03, 8'h04, 8'h08, 8'h10, 8'h11, 8'h20, 8'h21, 8'hFF};
	logic [7:0]  cl_st [9] = '{8'h00, 8'h00, 8'h04, 8'h08, 8'h10, 8'h00, 8'h20, 8'h00, 8'h00};
	logic [7:0]  cl_by [9] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h40, 8'h00, 8'h80, 8'h00, 8'h00};

	pwm_mask_regs u_pwm_mask_regs (.SYS_CLK_I(clk), .RST_I(rst), .ADDR_I(addr),
		.WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .ACC_ADDR_I(acc_addr),
		.ACC_VALID_I(acc_valid), .ACC_HIT_O(hit), .ACC_WIN_O(win),
		.ACC_BAR_PREFETCHABLE_FLAG_O(pf), .LINE_BYTES_O(line_bytes));
	pwm_host_model u_pwm_host_model (.clk_i(clk), .rdata_i(rdata), .hit_i(hit),
		.win_i(win), .pf_i(pf), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
		.acc_addr_o(acc_addr), .acc_valid_o(acc_valid));

	// ==========================================
	// clock, and verdict in one place
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : report_and_stop

	// ==========================================
	// watchdog, far beyond the fewer than two hundred cycles of the tests
	initial begin
		#(20000 * 5);
		miscompares++;
		report_and_stop();
	end

	// ==========================================
	// test sequence
	initial begin
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		// reset value of each of the six masks
		for (int n = 0; n < 6; n++) begin
			u_pwm_host_model.rd(OFS_MASK0 + 8'(4 * n), d);
			`CHK(d, MASK_RESET)
		end
		// per-window size mask gates mirror writes, bit 3 shows bar_prefetchable_flag
		for (int n = 0; n < 6; n++) begin
			m = (32'hFFFF_FFF0 << (4 * n)) | (n[0] ? 32'h0000_0008 : 32'h0000_0000);
			u_pwm_host_model.wr(OFS_MASK0 + 8'(4 * n), m | 32'h0000_0007);
			u_pwm_host_model.rd(OFS_MASK0 + 8'(4 * n), d);
			`CHK(d, m)
			u_pwm_host_model.wr(OFS_MIRROR0 + 8'(4 * n), 32'hFFFF_FFFF);
			u_pwm_host_model.rd(OFS_MIRROR0 + 8'(4 * n), d);
			`CHK(d, m)
			old = m & MASK_FIELD;
			u_pwm_host_model.wr(OFS_MIRROR0 + 8'(4 * n), 32'h5A5A_5A5A);
			e = (old & ~m & MASK_FIELD) | (32'h5A5A_5A5A & m & MASK_FIELD) | (m & 32'h8);
			u_pwm_host_model.rd(OFS_MIRROR0 + 8'(4 * n), d);
			`CHK(d, e)
			`CHK(d[PREF_BIT], m[PREF_BIT])
		end
		// unmapped place reads zero, writes vanish
		u_pwm_host_model.wr(8'h18, 32'hFFFF_FFFF);
		u_pwm_host_model.rd(8'h18, d);
		`CHK(d, 32'h0000_0000)
		// every cache line length class
		for (int i = 0; i < 9; i++) begin
			u_pwm_host_model.wr(OFS_CACHE_LINE, {24'h00_0000, cl_in[i]});
			u_pwm_host_model.rd(OFS_CACHE_LINE, d);
			`CHK(d, {24'h00_0000, cl_st[i]})
			u_pwm_host_model.rd(OFS_LINE_BYTES, d);
			`CHK(d, {24'h00_0000, cl_by[i]})
			`CHK(line_bytes, cl_by[i])
		end
		// window 2 decode, first disabled then enabled
		u_pwm_host_model.wr(OFS_MASK0 + 8'h08, 32'hFFFF_0008);
		u_pwm_host_model.wr(OFS_MIRROR0 + 8'h08, 32'h1234_0000);
		u_pwm_host_model.acc(32'h1234_5678, h_s, w_s, p_s);
		`CHK({h_s, w_s, p_s}, 5'b0_000_0)
		u_pwm_host_model.wr(OFS_WIN_ENABLE, 32'h0000_0004);
		u_pwm_host_model.rd(OFS_WIN_ENABLE, d);
		`CHK(d, 32'h0000_0004)
		u_pwm_host_model.acc(32'h1234_5678, h_s, w_s, p_s);
		`CHK({h_s, w_s, p_s}, 5'b1_010_1)
		u_pwm_host_model.acc(32'h1235_0000, h_s, w_s, p_s);
		`CHK(h_s, 1'b0)
		u_pwm_host_model.wr(OFS_WIN_ENABLE, 32'h0000_0000);
		u_pwm_host_model.acc(32'h1234_0000, h_s, w_s, p_s);
		`CHK(h_s, 1'b0)
		// narrower mask, unmasked mirror bits keep their earlier value
		u_pwm_host_model.wr(OFS_MASK0, 32'hFF00_0000);
		u_pwm_host_model.wr(OFS_MIRROR0, 32'h0000_0000);
		u_pwm_host_model.rd(OFS_MIRROR0, d);
		`CHK(d, 32'h005A_5A50)
		report_and_stop();
	end
endmodule : pwm_mask_regs_tb
